// ==== hw/ssk_len_sum.sv ====
// Sums the byte lengths of the first one to three following instructions
`timescale 1ns/1ps
`default_nettype none
module ssk_len_sum (
    input  wire logic [ssk_pkg::LEN_W-1:0] len0_i,
    input  wire logic [ssk_pkg::LEN_W-1:0] len1_i,
    input  wire logic [ssk_pkg::LEN_W-1:0] len2_i,
    input  wire logic [ssk_pkg::CNT_W-1:0] count_i,
    output logic      [ssk_pkg::PC_W-1:0]  sum_o
);
    logic [ssk_pkg::LEN_W-1:0] len_vec [ssk_pkg::NUM_LEN];
    logic [ssk_pkg::LEN_W-1:0] masked  [ssk_pkg::NUM_LEN];

    assign len_vec[0] = len0_i;
    assign len_vec[1] = len1_i;
    assign len_vec[2] = len2_i;

    // Only the first count entries contribute
    for (genvar i = 0; i < ssk_pkg::NUM_LEN; i++) begin : g_mask
        assign masked[i] = (count_i > ssk_pkg::CNT_W'(i)) ? len_vec[i] : '0;
    end

    assign sum_o = ssk_pkg::PC_W'(masked[0]) + ssk_pkg::PC_W'(masked[1]) + ssk_pkg::PC_W'(masked[2]);
endmodule
`default_nettype wire

// ==== hw/ssk_pkg.sv ====
// Shared constants and types for the sign and skip instruction unit
package ssk_pkg;
    localparam int ACC_W = 24;
    localparam int PC_W  = 16;
    localparam int LEN_W = 3;
    localparam int OP_W  = 3;
    localparam int CNT_W = 2;
    localparam int BIT_W = 5;
    localparam int REM_W = 2;
    localparam int NUM_LEN = 3;

    // Instruction codes presented by the decoder
    localparam logic [OP_W-1:0] OP_SIGN          = 3'h0;
    localparam logic [OP_W-1:0] OP_SKIP          = 3'h1;
    localparam logic [OP_W-1:0] OP_BIT_LOW       = 3'h2;
    localparam logic [OP_W-1:0] OP_BIT_HIGH      = 3'h3;
    localparam logic [OP_W-1:0] OP_CARRY_LOW     = 3'h4;
    localparam logic [OP_W-1:0] OP_CARRY_HIGH    = 3'h5;
    localparam logic [OP_W-1:0] OP_RESULT_ZERO   = 3'h6;
    localparam logic [OP_W-1:0] OP_RESULT_NONZERO = 3'h7;

    localparam logic [ACC_W-1:0] ACC_PLUS_ONE  = 24'h000001;
    localparam logic [ACC_W-1:0] ACC_MINUS_ONE = 24'hffffff;
    localparam logic [ACC_W-1:0] ACC_ZERO      = 24'h000000;
    localparam int               SIGN_BIT      = 23;
    localparam logic [BIT_W-1:0] TOP_BIT_SEL   = 5'h17;

    // Cycle counts
    localparam logic [REM_W:0] SIGN_CYCLES      = 3'h2;
    localparam logic [REM_W:0] SKIP_BASE_CYCLES = 3'h1;
    localparam logic [REM_W-1:0] REM_ZERO       = 2'h0;
    localparam logic [REM_W-1:0] REM_ONE        = 2'h1;

    typedef enum logic [1:0] {
        SSK_IDLE = 2'b01,
        SSK_RUN  = 2'b10
    } ssk_state_e;
endpackage

// ==== hw/ssk_unit.sv ====
// Execution unit for the sign instruction and the skip instruction family
// Overview of operation
// - Sign on a zero or positive accumulator writes back the 24-bit value one.
// - Sign on a negative accumulator writes back all ones, which is minus one.
// - Sign reads x, y, z or r as two's complement and writes the result back to it, along with the sign and zero flags.
// - An operand of exactly zero counts as positive, so it yields plus one.
// - A taken skip adds the summed byte lengths of the next one, two or three instructions to the counter.
// - The unconditional skip advances the counter with no test whenever the count is nonzero.
// - Every skip takes one cycle, plus one per skipped instruction when taken.
// - The bit-low skip tests bit 0 to 23 of an accumulator and skips when it reads zero.
// - The bit-high skip tests the chosen bit and skips when it reads one.
// - The carry-low skip skips only when carry is 0.
// - The carry-high skip skips only when carry is 1.
// - The result-zero skip skips when the non-zero flag is 0.
// - The result-nonzero skip skips when the non-zero flag is 1.
`timescale 1ns/1ps
`default_nettype none
module ssk_unit (
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       start_i,
    input  wire logic [ssk_pkg::OP_W-1:0]   op_i,
    input  wire logic [1:0]                 acc_sel_i,
    input  wire logic [ssk_pkg::BIT_W-1:0]  bit_sel_i,
    input  wire logic [ssk_pkg::CNT_W-1:0]  count_i,
    input  wire logic [ssk_pkg::ACC_W-1:0]  acc_x_i,
    input  wire logic [ssk_pkg::ACC_W-1:0]  acc_y_i,
    input  wire logic [ssk_pkg::ACC_W-1:0]  acc_z_i,
    input  wire logic [ssk_pkg::ACC_W-1:0]  acc_r_i,
    input  wire logic                       carry_i,
    input  wire logic                       nonzero_i,
    input  wire logic [ssk_pkg::PC_W-1:0]   pc_i,
    input  wire logic [ssk_pkg::LEN_W-1:0]  len0_i,
    input  wire logic [ssk_pkg::LEN_W-1:0]  len1_i,
    input  wire logic [ssk_pkg::LEN_W-1:0]  len2_i,
    output logic                            busy_o,
    output logic                            done_o,
    output logic                            taken_o,
    output logic                            pc_load_o,
    output logic      [ssk_pkg::PC_W-1:0]   program_counter_o,
    output logic                            acc_wr_o,
    output logic      [1:0]                 acc_wr_sel_o,
    output logic      [ssk_pkg::ACC_W-1:0]  acc_wr_data_o,
    output logic                            flag_wr_o,
    output logic                            sign_flag_o,
    output logic                            zero_flag_o
);
    ssk_pkg::ssk_state_e         state_q, state_d;
    logic [ssk_pkg::REM_W-1:0]   rem_q, rem_d;
    logic [ssk_pkg::OP_W-1:0]    op_q;
    logic                        busy_q, done_q, taken_q, pc_load_q, acc_wr_q, flag_wr_q;
    logic                        sign_flag_q, zero_flag_q;
    logic [1:0]                  sel_q;
    logic [ssk_pkg::PC_W-1:0]    pc_q;
    logic [ssk_pkg::ACC_W-1:0]   data_q;

    logic [ssk_pkg::ACC_W-1:0]   acc_vec [4];
    logic [ssk_pkg::ACC_W-1:0]   acc_val;
    logic [ssk_pkg::ACC_W-1:0]   sign_res;
    logic [ssk_pkg::PC_W-1:0]    skip_bytes;
    logic [ssk_pkg::REM_W:0]     total_cyc;
    logic                        running, accept, finish, is_sign, bit_val;
    logic                        hit_uncond, hit_bit_low, hit_bit_high, hit_carry_low;
    logic                        hit_carry_high, hit_res_zero, hit_res_nonzero, skip_hit;

    assign acc_vec[0] = acc_x_i;
    assign acc_vec[1] = acc_y_i;
    assign acc_vec[2] = acc_z_i;
    assign acc_vec[3] = acc_r_i;
    assign acc_val  = acc_vec[acc_sel_i];
    assign running  = (state_q == ssk_pkg::SSK_RUN);
    // Requests while busy are ignored, never queued
    assign accept   = start_i && (state_q == ssk_pkg::SSK_IDLE);
    assign finish   = running && (rem_q == ssk_pkg::REM_ZERO);
    assign is_sign  = (op_i == ssk_pkg::OP_SIGN);

    // sign result, zero taken as positive
    assign sign_res = acc_val[ssk_pkg::SIGN_BIT] ? ssk_pkg::ACC_MINUS_ONE : ssk_pkg::ACC_PLUS_ONE;

    // bit range guard, positions above 23 read as zero
    assign bit_val  = (bit_sel_i <= ssk_pkg::TOP_BIT_SEL) ? acc_val[bit_sel_i] : 1'b0;

    assign hit_uncond      = (op_i == ssk_pkg::OP_SKIP);
    assign hit_bit_low     = (op_i == ssk_pkg::OP_BIT_LOW) && !bit_val;
    assign hit_bit_high    = (op_i == ssk_pkg::OP_BIT_HIGH) && bit_val;
    assign hit_carry_low   = (op_i == ssk_pkg::OP_CARRY_LOW) && !carry_i;
    assign hit_carry_high  = (op_i == ssk_pkg::OP_CARRY_HIGH) && carry_i;
    assign hit_res_zero    = (op_i == ssk_pkg::OP_RESULT_ZERO) && !nonzero_i;
    assign hit_res_nonzero = (op_i == ssk_pkg::OP_RESULT_NONZERO) && nonzero_i;

    assign skip_hit = (hit_uncond || hit_bit_low || hit_bit_high || hit_carry_low
                    || hit_carry_high || hit_res_zero || hit_res_nonzero) && (count_i != '0);

    // byte lengths of the skipped instructions
    ssk_len_sum u_len_sum (
        .len0_i  (len0_i),
        .len1_i  (len1_i),
        .len2_i  (len2_i),
        .count_i (count_i),
        .sum_o   (skip_bytes)
    );

    // one base cycle plus one per skipped instruction
    assign total_cyc = is_sign ? ssk_pkg::SIGN_CYCLES
                     : ssk_pkg::SKIP_BASE_CYCLES + (skip_hit ? (ssk_pkg::REM_W+1)'(count_i) : '0);

    assign state_d = accept ? ssk_pkg::SSK_RUN : (finish ? ssk_pkg::SSK_IDLE : state_q);
    assign rem_d   = accept ? ssk_pkg::REM_W'(total_cyc - ssk_pkg::SKIP_BASE_CYCLES)
                   : (running ? rem_q - ssk_pkg::REM_ONE : rem_q);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ssk_pkg::SSK_IDLE;
            rem_q   <= ssk_pkg::REM_ZERO;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            rem_q   <= rem_d;
            busy_q  <= (state_d == ssk_pkg::SSK_RUN);
            done_q  <= finish;
        end
    end

    // Results are captured at acceptance and drive the outputs from then on; the load and write strobes pulse with done
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_q        <= ssk_pkg::OP_SKIP;
            taken_q     <= 1'b0;
            sel_q       <= 2'h0;
            pc_q        <= '0;
            data_q      <= ssk_pkg::ACC_ZERO;
            sign_flag_q <= 1'b0;
            zero_flag_q <= 1'b0;
        end else if (accept) begin
            op_q        <= op_i;
            taken_q     <= skip_hit && !is_sign;
            sel_q       <= acc_sel_i;
            pc_q        <= pc_i + skip_bytes;
            data_q      <= sign_res;
            sign_flag_q <= sign_res[ssk_pkg::SIGN_BIT];
            zero_flag_q <= (sign_res == ssk_pkg::ACC_ZERO);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_load_q <= 1'b0;
            acc_wr_q  <= 1'b0;
            flag_wr_q <= 1'b0;
        end else begin
            pc_load_q <= finish && taken_q;
            acc_wr_q  <= finish && (op_q == ssk_pkg::OP_SIGN);
            flag_wr_q <= finish && (op_q == ssk_pkg::OP_SIGN);
        end
    end

    assign busy_o            = busy_q;
    assign done_o            = done_q;
    assign taken_o           = taken_q;
    assign pc_load_o         = pc_load_q;
    assign program_counter_o = pc_q;
    assign acc_wr_o          = acc_wr_q;
    assign acc_wr_sel_o      = sel_q;
    assign acc_wr_data_o     = data_q;
    assign flag_wr_o         = flag_wr_q;
    assign sign_flag_o       = sign_flag_q;
    assign zero_flag_o       = zero_flag_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_sign_start;
        accept && is_sign;
    endsequence
    sequence s_skip_start;
        accept && !is_sign;
    endsequence

    a_sign_pos_one: assert property (s_sign_start ##0 !acc_val[ssk_pkg::SIGN_BIT] |->
        ##3 acc_wr_o && acc_wr_data_o == ssk_pkg::ACC_PLUS_ONE) else $error("sign of positive not one");
    a_sign_neg_ones: assert property (s_sign_start ##0 acc_val[ssk_pkg::SIGN_BIT] |->
        ##3 acc_wr_o && acc_wr_data_o == ssk_pkg::ACC_MINUS_ONE) else $error("sign of negative not all ones");
    a_sign_flag_pair: assert property (s_sign_start |->
        ##3 flag_wr_o && sign_flag_o == $past(acc_val[ssk_pkg::SIGN_BIT], 3) && !zero_flag_o
        && acc_wr_sel_o == $past(acc_sel_i, 3)) else $error("sign flags or target wrong");
    a_sign_zero_in: assert property (s_sign_start ##0 acc_val == ssk_pkg::ACC_ZERO |->
        ##3 acc_wr_data_o == ssk_pkg::ACC_PLUS_ONE) else $error("zero operand not treated as positive");
    a_skip_pc_sum: assert property (s_skip_start ##0 skip_hit && count_i == 2'h2 |->
        ##4 pc_load_o && program_counter_o == $past(pc_i, 4) + ssk_pkg::PC_W'($past(len0_i, 4))
        + ssk_pkg::PC_W'($past(len1_i, 4))) else $error("skip target not sum of lengths");
    a_skip_uncond_go: assert property (s_skip_start ##0 hit_uncond && count_i == 2'h1 |->
        ##1 busy_o [*2] ##1 done_o && taken_o && pc_load_o) else $error("unconditional skip not taken");
    a_skip_miss_time: assert property (s_skip_start ##0 !skip_hit |->
        ##1 busy_o ##1 done_o && !pc_load_o && !busy_o) else $error("untaken skip not one cycle");
    a_bit_low_take: assert property (s_skip_start ##0 hit_bit_low && count_i == 2'h3 |->
        ##1 busy_o [*4] ##1 done_o && taken_o) else $error("bit low skip timing wrong");
    a_bit_high_take: assert property (accept && op_i == ssk_pkg::OP_BIT_HIGH && count_i != '0 |->
        ##1 (taken_o == $past(bit_val)) ##[1:4] done_o) else $error("bit high skip wrong");
    a_carry_low: assert property (accept && op_i == ssk_pkg::OP_CARRY_LOW && carry_i |->
        ##2 done_o && !taken_o) else $error("carry low skip taken with carry set");
    a_carry_high: assert property (accept && op_i == ssk_pkg::OP_CARRY_HIGH && !carry_i |->
        ##2 done_o && !taken_o) else $error("carry high skip taken with carry clear");
    a_res_zero: assert property (accept && op_i == ssk_pkg::OP_RESULT_ZERO && nonzero_i |->
        ##2 done_o && !pc_load_o) else $error("result zero skip taken on nonzero");
    a_res_nonzero: assert property (accept && op_i == ssk_pkg::OP_RESULT_NONZERO && !nonzero_i |->
        ##2 done_o && !pc_load_o) else $error("result nonzero skip taken on zero");
    // Checked at the end pulse, since a sign accepted right after a short skip may write later
    a_skip_no_flags: assert property (done_o && op_q != ssk_pkg::OP_SIGN |->
        !flag_wr_o && !acc_wr_o) else $error("skip wrote flags");
    a_skip_done_bound: assert property (s_skip_start |-> ##[2:5] done_o) else $error("skip never ends");
endmodule
`default_nettype wire

// ==== tb/ssk_unit_tb_top.sv ====
// Self-checking bench for the sign and skip instruction unit
`timescale 1ns/1ps
`default_nettype none
module ssk_unit_tb_top;
    logic        core_clk_i;
    logic        rst_n_i;
    logic        start_i;
    logic [2:0]  op_i;
    logic [1:0]  acc_sel_i;
    logic [4:0]  bit_sel_i;
    logic [1:0]  count_i;
    logic [23:0] acc_x_i, acc_y_i, acc_z_i, acc_r_i;
    logic        carry_i;
    logic        nonzero_i;
    logic [15:0] pc_i;
    logic [2:0]  len0_i, len1_i, len2_i;
    logic        busy_o, done_o, taken_o, pc_load_o, acc_wr_o, flag_wr_o, sign_flag_o, zero_flag_o;
    logic [15:0] program_counter_o;
    logic [1:0]  acc_wr_sel_o;
    logic [23:0] acc_wr_data_o;
    int          failures;
    int          compares;
    int          cycles;

    ssk_unit uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
        .acc_sel_i(acc_sel_i), .bit_sel_i(bit_sel_i), .count_i(count_i), .acc_x_i(acc_x_i),
        .acc_y_i(acc_y_i), .acc_z_i(acc_z_i), .acc_r_i(acc_r_i), .carry_i(carry_i),
        .nonzero_i(nonzero_i), .pc_i(pc_i), .len0_i(len0_i), .len1_i(len1_i), .len2_i(len2_i),
        .busy_o(busy_o), .done_o(done_o), .taken_o(taken_o), .pc_load_o(pc_load_o),
        .program_counter_o(program_counter_o), .acc_wr_o(acc_wr_o), .acc_wr_sel_o(acc_wr_sel_o),
        .acc_wr_data_o(acc_wr_data_o), .flag_wr_o(flag_wr_o), .sign_flag_o(sign_flag_o),
        .zero_flag_o(zero_flag_o));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    task automatic complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Ceiling is several times the expected run length
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("mismatch at %0t: run did not finish", $time);
            complete_run();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // Unselected accumulators get the inverse so a wrong select shows up
    task automatic exec(input logic [2:0] op, input logic [1:0] sel, input logic [23:0] val,
                        input logic [4:0] bs, input logic [1:0] cnt, input logic cy,
                        input logic nz, input logic hold, output int cyc);
        @(posedge core_clk_i);
        op_i      <= op;
        acc_sel_i <= sel;
        bit_sel_i <= bs;
        count_i   <= cnt;
        carry_i   <= cy;
        nonzero_i <= nz;
        acc_x_i   <= (sel == 2'h0) ? val : ~val;
        acc_y_i   <= (sel == 2'h1) ? val : ~val;
        acc_z_i   <= (sel == 2'h2) ? val : ~val;
        acc_r_i   <= (sel == 2'h3) ? val : ~val;
        start_i   <= 1'b1;
        @(posedge core_clk_i);
        cyc = hold ? 1 : 0;
        // Second request while busy, with op, count and carry changed, must be ignored
        if (hold) begin
            op_i    <= ssk_pkg::OP_SIGN;
            count_i <= 2'h1;
            carry_i <= ~cy;
            @(posedge core_clk_i);
        end
        start_i <= 1'b0;
        do begin
            @(negedge core_clk_i);
            cyc++;
        end while (done_o !== 1'b1 && cyc < 12);
    endtask

    task automatic skip_case(input logic [2:0] op, input logic [1:0] sel, input logic [23:0] val,
                             input logic [4:0] bs, input logic [1:0] cnt, input logic cy,
                             input logic nz, input logic tk, input logic hold);
        int cyc;
        int n;
        exec(op, sel, val, bs, cnt, cy, nz, hold, cyc);
        n = cnt;
        check(cyc, tk ? n + 2 : 2, "skip duration");
        check(taken_o, tk, "skip decision");
        check(pc_load_o, tk, "counter load pulse");
        if (tk) check(program_counter_o, 16'h1230 + n * (n + 1) / 2, "counter target");
        check({acc_wr_o, flag_wr_o}, 2'b00, "skip wrote state");
    endtask

    task automatic sign_case(input logic [1:0] sel, input logic [23:0] val);
        int cyc;
        exec(ssk_pkg::OP_SIGN, sel, val, 5'h0, 2'h0, 1'b0, 1'b0, 1'b0, cyc);
        check(cyc, 3, "sign duration");
        check(acc_wr_data_o, val[23] ? 24'hffffff : 24'h000001, "sign result");
        check({acc_wr_o, flag_wr_o, pc_load_o, acc_wr_sel_o}, {3'b110, sel}, "sign write");
        check({sign_flag_o, zero_flag_o}, {val[23], 1'b0}, "sign flags");
    endtask

    task automatic test_sign;
        for (int s = 0; s < 4; s++) begin
            sign_case(s[1:0], 24'h000000);
            sign_case(s[1:0], 24'h7fffff);
            sign_case(s[1:0], 24'h800000);
            sign_case(s[1:0], 24'hffffff);
        end
        $display("test sign finished");
    endtask

    task automatic test_uncond;
        for (int n = 1; n < 4; n++) begin
            skip_case(ssk_pkg::OP_SKIP, 2'h0, 24'h0, 5'h0, n[1:0], 1'b0, 1'b0, 1'b1, 1'b0);
            skip_case(ssk_pkg::OP_SKIP, 2'h1, 24'h0, 5'h0, n[1:0], 1'b1, 1'b1, 1'b1, 1'b0);
        end
        skip_case(ssk_pkg::OP_SKIP, 2'h0, 24'h0, 5'h0, 2'h3, 1'b0, 1'b1, 1'b1, 1'b1);
        // A count of zero skips nothing and takes the single base cycle
        skip_case(ssk_pkg::OP_SKIP, 2'h2, 24'h0, 5'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("test unconditional finished");
    endtask

    task automatic test_bits;
        logic [23:0] v;
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 24; b += 23) begin
                v = 24'h000001 << b;
                skip_case(ssk_pkg::OP_BIT_LOW, s[1:0], v, b[4:0], 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
                skip_case(ssk_pkg::OP_BIT_LOW, s[1:0], ~v, b[4:0], 2'h3, 1'b0, 1'b0, 1'b1, 1'b0);
                skip_case(ssk_pkg::OP_BIT_HIGH, s[1:0], v, b[4:0], 2'h2, 1'b0, 1'b0, 1'b1, 1'b0);
                skip_case(ssk_pkg::OP_BIT_HIGH, s[1:0], ~v, b[4:0], 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
            end
        end
        // Positions above the top bit read as zero
        skip_case(ssk_pkg::OP_BIT_HIGH, 2'h3, 24'hffffff, 5'h18, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        skip_case(ssk_pkg::OP_BIT_LOW, 2'h3, 24'hffffff, 5'h1f, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0);
        $display("test bit skips finished");
    endtask

    // The flag not under test is set opposite so a swapped source is caught
    task automatic test_flags;
        logic f;
        for (int i = 0; i < 2; i++) begin
            f = i[0];
            skip_case(ssk_pkg::OP_CARRY_LOW, 2'h0, 24'h0, 5'h0, 2'h2, f, ~f, ~f, 1'b0);
            skip_case(ssk_pkg::OP_CARRY_HIGH, 2'h0, 24'h0, 5'h0, 2'h3, f, ~f, f, 1'b0);
            skip_case(ssk_pkg::OP_RESULT_ZERO, 2'h0, 24'h0, 5'h0, 2'h2, ~f, f, ~f, 1'b0);
            skip_case(ssk_pkg::OP_RESULT_NONZERO, 2'h0, 24'h0, 5'h0, 2'h1, ~f, f, f, 1'b0);
        end
        $display("test flag skips finished");
    endtask

    initial begin
        failures = 0;
        compares = 0;
        cycles = 0;
        rst_n_i = 1'b0;
        start_i = 1'b0;
        op_i = 3'h0;
        acc_sel_i = 2'h0;
        bit_sel_i = 5'h0;
        count_i = 2'h0;
        {acc_x_i, acc_y_i, acc_z_i, acc_r_i} = '0;
        carry_i = 1'b0;
        nonzero_i = 1'b0;
        pc_i = 16'h1230;
        len0_i = 3'h1;
        len1_i = 3'h2;
        len2_i = 3'h3;
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(negedge core_clk_i);
        check({busy_o, done_o, program_counter_o}, 18'h0, "reset state");
        test_sign();
        test_uncond();
        test_bits();
        test_flags();
        complete_run();
    end
endmodule
`default_nettype wire
